// file: fifo_status_csr.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_status_csr
    import fifo_status_csr_pkg::*;
#(
    parameter bit DUAL_CLOCK = 1'b0
)
(
    // Clock, reset, enable (the side's own clock in dual-clock builds)
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Register port
    input wire csr_req_t req,
    output logic [31:0] rdata,
    // Queue state
    input wire queue_state_t queue,
    // Interrupt
    output logic irq
);
    localparam logic [31:0] HIGH_MAX = DUAL_CLOCK ? HIGH_DEFAULT_DUAL : HIGH_DEFAULT_SINGLE;

    logic [5:0] live;
    logic [5:0] sticky_q, sticky_d;
    logic [6:0] mask_q, mask_d;
    logic [31:0] high_q, high_d;
    logic [31:0] low_q, low_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic [5:0] mask_eff;

    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] hi);
        if (v < MARK_MIN)
            return MARK_MIN;
        else if (v > hi)
            return hi;
        else
            return v;
    endfunction : clamp

    always_comb
    begin
        live = '0;
        live[BIT_FULL] = (queue.occupancy >= 32'(DEPTH));
        live[BIT_EMPTY] = (queue.occupancy == 32'h0000_0000);
        live[BIT_HIGH] = (queue.occupancy >= high_q);
        live[BIT_LOW] = (queue.occupancy <= low_q);
        live[BIT_OVERFLOW] = queue.write_when_full;
        live[BIT_UNDERFLOW] = queue.read_when_empty;
    end

    always_comb
    begin
        sticky_d = sticky_q;
        mask_d = mask_q;
        high_d = high_q;
        low_d = low_q;
        rdata_d = rdata_q;
        if (req.wr)
        begin
            case (req.addr)
                OFS_STICKY: sticky_d = sticky_q & ~req.wdata[5:0];
                OFS_IRQ_MASK: mask_d = req.wdata[6:0];
                OFS_HIGH_MARK: high_d = clamp(req.wdata, HIGH_MAX);
                OFS_LOW_MARK: low_d = clamp(req.wdata, HIGH_MAX);
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        sticky_d = sticky_d | live;
        // Mask taken from its next value so irq tracks masked sticky flags exactly
        mask_eff = mask_d[5:0] | {NUM_COND{mask_d[BIT_MASK_ALL]}};
        if (req.rd)
        begin
            case (req.addr)
                OFS_OCCUPANCY: rdata_d = queue.occupancy;
                OFS_LIVE: rdata_d = {26'h0, live};
                OFS_STICKY: rdata_d = {26'h0, sticky_q};
                OFS_IRQ_MASK: rdata_d = {25'h0, mask_q};
                OFS_HIGH_MARK: rdata_d = high_q;
                OFS_LOW_MARK: rdata_d = low_q;
                default: rdata_d = 32'h0;
            endcase
        end
        irq_d = |(sticky_d & mask_eff);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sticky_q <= STICKY_RESET;
            mask_q <= IRQ_MASK_RESET;
            high_q <= HIGH_MAX;
            low_q <= LOW_DEFAULT;
            rdata_q <= 32'h0;
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sticky_q <= sticky_d;
            mask_q <= mask_d;
            high_q <= high_d;
            low_q <= low_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;

    chk_sticky_set_live: assert property (@(posedge clk) disable iff (reset)
        clk_en && live[BIT_FULL] |=> sticky_q[BIT_FULL])
        else $error("sticky full not set by live full");
    chk_sticky_hold_zero: assert property (@(posedge clk) disable iff (reset)
        clk_en && !(req.wr && req.addr == OFS_STICKY)
        |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
        else $error("sticky flag cleared without a write");
    chk_sticky_w1c: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && req.addr == OFS_STICKY && req.wdata[0] && !live[0]
        |=> !sticky_q[0])
        else $error("sticky bit not cleared by written one");
    chk_irq_level: assert property (@(posedge clk) disable iff (reset)
        clk_en |=> irq == |(sticky_q & (mask_q[5:0] | {6{mask_q[6]}})))
        else $error("irq does not follow masked sticky flags");
    chk_high_clamp: assert property (@(posedge clk) disable iff (reset)
        high_q >= MARK_MIN && high_q <= HIGH_MAX)
        else $error("high watermark out of range");
    chk_low_clamp: assert property (@(posedge clk) disable iff (reset)
        low_q >= MARK_MIN && low_q <= HIGH_MAX)
        else $error("low watermark out of range");
    chk_mask_all_irq: assert property (@(posedge clk) disable iff (reset)
        clk_en && mask_q[6] && live[BIT_OVERFLOW] ##1 clk_en |=> irq)
        else $error("all-mask bit did not raise irq");
    chk_live_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_LIVE |=> rdata == {26'h0, $past(live)})
        else $error("live condition read mismatch");
    chk_occ_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_OCCUPANCY |=> rdata == $past(queue.occupancy))
        else $error("occupancy read mismatch");

    // Values seen on the first edge after reset
    chk_high_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> high_q == HIGH_MAX)
        else $error("high watermark not at default after reset");
    chk_low_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> low_q == LOW_DEFAULT)
        else $error("low watermark not at default after reset");
    chk_sticky_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> sticky_q == STICKY_RESET)
        else $error("sticky flags not clear after reset");
    chk_irq_reset: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> !irq)
        else $error("irq high after reset");

    // Clock enable low freezes every register
    chk_freeze_flags: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(sticky_q) && $stable(mask_q))
        else $error("flags or mask changed while frozen");
    chk_freeze_marks: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(high_q) && $stable(low_q) && $stable(rdata))
        else $error("watermarks or read data changed while frozen");

    // Read path
    chk_sticky_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_STICKY |=> rdata == {26'h0, $past(sticky_q)})
        else $error("sticky read mismatch");
    chk_mask_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_IRQ_MASK |=> rdata == {25'h0, $past(mask_q)})
        else $error("mask read mismatch");
    chk_high_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_HIGH_MARK |=> rdata == $past(high_q))
        else $error("high watermark read mismatch");
    chk_low_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_LOW_MARK |=> rdata == $past(low_q))
        else $error("low watermark read mismatch");
    chk_hole_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr > OFS_LOW_MARK |=> rdata == 32'h0)
        else $error("unmapped word did not read zero");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (reset)
        clk_en && !req.rd |=> $stable(rdata))
        else $error("read data changed without a read");

    // Write path
    chk_mask_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && req.addr == OFS_IRQ_MASK |=> mask_q == $past(req.wdata[6:0]))
        else $error("mask write not stored");
    chk_high_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && req.addr == OFS_HIGH_MARK
        && req.wdata >= MARK_MIN && req.wdata <= HIGH_MAX
        |=> high_q == $past(req.wdata))
        else $error("in-range high watermark not stored");
    chk_low_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && req.addr == OFS_LOW_MARK
        && req.wdata >= MARK_MIN && req.wdata <= HIGH_MAX
        |=> low_q == $past(req.wdata))
        else $error("in-range low watermark not stored");
    chk_hole_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.wr && (req.addr <= OFS_LIVE || req.addr > OFS_LOW_MARK)
        |=> $stable(mask_q) && $stable(high_q) && $stable(low_q))
        else $error("write to read-only or unmapped word changed state");

    // Event flags and interrupt
    chk_ovf_sticky: assert property (@(posedge clk) disable iff (reset)
        clk_en && queue.write_when_full |=> sticky_q[BIT_OVERFLOW])
        else $error("write-when-full pulse not latched");
    chk_unf_sticky: assert property (@(posedge clk) disable iff (reset)
        clk_en && queue.read_when_empty |=> sticky_q[BIT_UNDERFLOW])
        else $error("read-when-empty pulse not latched");
    chk_empty_live: assert property (@(posedge clk) disable iff (reset)
        clk_en && req.rd && req.addr == OFS_LIVE && queue.occupancy == 32'h0
        |=> rdata[BIT_EMPTY] && !rdata[BIT_FULL])
        else $error("empty queue not shown as empty");
    chk_irq_rise: assert property (@(posedge clk) disable iff (reset)
        clk_en && !(req.wr && req.addr == OFS_IRQ_MASK)
        && |(live & (mask_q[5:0] | {6{mask_q[6]}}))
        |=> irq)
        else $error("masked new event did not raise irq");
endmodule : fifo_status_csr
`default_nettype wire

// file: fifo_status_csr_pkg.sv
// What this block does
// - The occupancy register reads back the queue's present fill level, in symbols or words.
// - The live condition register shows the queue's six conditions each cycle, unlatched.
// - Each sticky flag bit is set whenever its matching live condition bit is one.
// - A sticky flag clears only on a written one; zero writes and hardware leave it alone.
// - The interrupt is high while any sticky bit is one with its mask bit or mask bit 6 set.
// - The interrupt mask register is read/write, seven bits: six laid out like the flag registers plus bit 6.
// - The high watermark is writable any time and resets to depth minus four or minus one.
// - High watermark writes are clamped between one and its reset default.
// - The low watermark is writable any time and resets to one.
// - Low watermark writes are clamped between one and the largest legal high watermark.
// - Input-side and output-side banks share one identical register layout.
// - Condition bits 0 to 3 are full, empty, at or above high mark, at or below low mark.
// - Condition bits 4 and 5 are one-cycle pulses for write-when-full and read-when-empty.
// - Mask bit 6 enables all six conditions onto the interrupt at once.
// - In dual-clock builds each bank runs on its own side's clock.
package fifo_status_csr_pkg;
    localparam int unsigned DEPTH = 16;
    localparam int unsigned NUM_COND = 6;
    localparam logic [2:0] OFS_OCCUPANCY = 3'h0;
    localparam logic [2:0] OFS_LIVE = 3'h1;
    localparam logic [2:0] OFS_STICKY = 3'h2;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h3;
    localparam logic [2:0] OFS_HIGH_MARK = 3'h4;
    localparam logic [2:0] OFS_LOW_MARK = 3'h5;
    localparam int unsigned BIT_FULL = 0;
    localparam int unsigned BIT_EMPTY = 1;
    localparam int unsigned BIT_HIGH = 2;
    localparam int unsigned BIT_LOW = 3;
    localparam int unsigned BIT_OVERFLOW = 4;
    localparam int unsigned BIT_UNDERFLOW = 5;
    localparam int unsigned BIT_MASK_ALL = 6;
    localparam logic [31:0] HIGH_DEFAULT_DUAL = 32'(DEPTH - 4);
    localparam logic [31:0] HIGH_DEFAULT_SINGLE = 32'(DEPTH - 1);
    localparam logic [31:0] LOW_DEFAULT = 32'h0000_0001;
    localparam logic [31:0] MARK_MIN = 32'h0000_0001;
    localparam logic [6:0] IRQ_MASK_RESET = 7'h00;
    localparam logic [5:0] STICKY_RESET = 6'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [31:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic write_when_full;
        logic read_when_empty;
        logic [31:0] occupancy;
    } queue_state_t;
endpackage : fifo_status_csr_pkg

// file: csr_master.sv
`timescale 1ns/1ps
`default_nettype none
module csr_master
    import fifo_status_csr_pkg::*;
(
    // Bus
    input wire logic clk,
    input wire logic [31:0] rdata,
    output var csr_req_t req
);
    initial req = '0;
    // One strobe pulse per word, read data taken after the taking edge
    task automatic access(input logic w, input logic [2:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(negedge clk);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
        q = rdata;
    endtask : access
endmodule : csr_master
`default_nettype wire

// file: fifo_status_csr_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_status_csr_tb
    import fifo_status_csr_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    csr_req_t req;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] rdata_dual;
    logic irq_dual;
    logic clk_en = 1'b1;
    queue_state_t queue = '{1'b0, 1'b0, 32'h5};
    int n_fail = 0;
    int checks = 0;
    always #5 clk = ~clk;
    fifo_status_csr #(.DUAL_CLOCK(1'b0)) uut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .req(req), .rdata(rdata), .queue(queue), .irq(irq));
    fifo_status_csr #(.DUAL_CLOCK(1'b1)) uut_dual (.clk(clk), .reset(reset), .clk_en(clk_en),
        .req(req), .rdata(rdata_dual), .queue(queue), .irq(irq_dual));
    csr_master m (.clk(clk), .rdata(rdata), .req(req));
    task automatic stop_test();
        $display("n_fail=%0d checks=%0d", n_fail, checks);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        m.access(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        logic [31:0] q;
        m.access(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    task automatic pulse(input logic ovf);
        @(negedge clk);
        queue.write_when_full = ovf;
        queue.read_when_empty = !ovf;
        @(negedge clk);
        queue.write_when_full = 1'b0;
        queue.read_when_empty = 1'b0;
    endtask : pulse
    task automatic t_marks();
        rd(OFS_HIGH_MARK, HIGH_DEFAULT_SINGLE);
        chk(rdata_dual, HIGH_DEFAULT_DUAL);
        rd(OFS_LOW_MARK, LOW_DEFAULT);
        rd(OFS_IRQ_MASK, 32'h0);
        wr(OFS_HIGH_MARK, 32'h0);
        rd(OFS_HIGH_MARK, MARK_MIN);
        wr(OFS_HIGH_MARK, 32'h64);
        rd(OFS_HIGH_MARK, HIGH_DEFAULT_SINGLE);
        chk(rdata_dual, HIGH_DEFAULT_DUAL);
        wr(OFS_LOW_MARK, 32'h0);
        rd(OFS_LOW_MARK, MARK_MIN);
        wr(OFS_LOW_MARK, 32'h64);
        rd(OFS_LOW_MARK, HIGH_DEFAULT_SINGLE);
        chk(rdata_dual, HIGH_DEFAULT_DUAL);
        wr(OFS_LOW_MARK, 32'h2);
    endtask : t_marks
    task automatic t_live();
        rd(OFS_OCCUPANCY, 32'h5);
        rd(OFS_LIVE, 32'h0);
        queue.occupancy = 32'h10;
        rd(OFS_LIVE, 32'h5);
        queue.occupancy = 32'h0;
        rd(OFS_LIVE, 32'ha);
        queue.occupancy = 32'h5;
    endtask : t_live
    task automatic t_sticky();
        wr(OFS_STICKY, 32'h3f);
        rd(OFS_STICKY, 32'h0);
        pulse(1'b1);
        rd(OFS_STICKY, 32'h10);
        wr(OFS_STICKY, 32'h0);
        rd(OFS_STICKY, 32'h10);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h10);
        rd(OFS_IRQ_MASK, 32'h10);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STICKY, 32'h10);
        rd(OFS_STICKY, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h40);
        pulse(1'b0);
        rd(OFS_STICKY, 32'h20);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, irq_dual}, 32'h1);
        wr(OFS_IRQ_MASK, 32'hffffffff);
        rd(OFS_IRQ_MASK, 32'h7f);
        wr(3'h6, 32'h1);
        rd(3'h6, 32'h0);
        clk_en = 1'b0;
        wr(OFS_IRQ_MASK, 32'h0);
        clk_en = 1'b1;
        rd(OFS_IRQ_MASK, 32'h7f);
    endtask : t_sticky
    initial
    begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        t_marks();
        t_live();
        t_sticky();
        stop_test();
    end
    initial
    begin
        #20000;
        n_fail++;
        stop_test();
    end
endmodule : fifo_status_csr_tb
`default_nettype wire
